// ===== design/dual_dac_host.v
// host controller that writes codes into the two converter channel latches
`include "dual_dac_host_regs.vh"

// Operation
// [R01] device offers two write-only byte locations; nothing is read back
// [R02] each channel is written only via its own active-low select
// [R03] latch is transparent while strobe and select are both low
// [R04] latch captures on whichever of select or strobe rises first
// [R05] latch holds while strobe or select is high
// [R06] host may keep write strobe low and latch with select alone
// [R07] both selects low together load both channels with one code
// [R08] host may tie strobe to the selects so one signal does both
// [R09] code bus is 8-bit unsigned, bit zero least significant
// [R10] host keeps code bus stable through the rising edge ending a write
module dual_dac_host (
    // clock and reset
    input  wire               clk_sys,
    input  wire               sys_rst,
    // user request
    input  wire               req_valid,
    output wire               req_ready,
    input  wire [1:0]         req_chan,
    input  wire [7:0]         req_code,
    input  wire [1:0]         strobe_mode,
    output wire               write_done,
    // user-side shadow of last written codes
    output wire [7:0]         shadow_a,
    output wire [7:0]         shadow_b,
    // converter pins
    output wire [7:0]         code_bus,
    output wire               write_strobe_n,
    output wire               chan_a_select_n,
    output wire               chan_b_select_n
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_SETUP  = 2'h1;
    localparam [1:0] ST_STROBE = 2'h2;
    localparam [1:0] ST_HOLD   = 2'h3;

    reg  [1:0]         state_q;
    reg  [1:0]         state_d;
    reg  [7:0]         code_q;
    reg  [1:0]         chan_q;
    reg  [1:0]         mode_q;
    reg                wr_n_q;
    reg                wr_n_d;
    reg                sel_a_n_q;
    reg                sel_a_n_d;
    reg                sel_b_n_q;
    reg                sel_b_n_d;
    reg  [7:0]         shadow_a_q;
    reg  [7:0]         shadow_b_q;
    reg                done_q;
    reg                tmr_load;
    reg  [`CNT_W-1:0]  tmr_count;
    wire               tmr_done;
    wire               accept;

    phase_timer u_timer (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .load    (tmr_load),
        .count   (tmr_count),
        .done    (tmr_done)
    );

    // a request with no channel named is refused rather than swallowed
    assign req_ready = (state_q == ST_IDLE);
    assign accept    = req_valid && req_ready && (req_chan != 2'h0);

    // [R01] write only, no read path
    assign code_bus        = code_q;
    assign write_strobe_n  = wr_n_q;
    assign chan_a_select_n = sel_a_n_q;
    assign chan_b_select_n = sel_b_n_q;
    assign shadow_a        = shadow_a_q;
    assign shadow_b        = shadow_b_q;
    assign write_done      = done_q;

    // ====================================================================
    // sequencer
    always @*
    begin
        state_d   = state_q;
        wr_n_d    = wr_n_q;
        sel_a_n_d = sel_a_n_q;
        sel_b_n_d = sel_b_n_q;
        tmr_load  = 1'b0;
        tmr_count = `SETUP_CYC;
        case (state_q)
            ST_IDLE:
            begin
                // [R06] strobe parked low in this mode
                wr_n_d = (mode_q == `MODE_WR_LOW) ? 1'b0 : 1'b1;
                if (accept)
                begin
                    state_d   = ST_SETUP;
                    tmr_load  = 1'b1;
                    tmr_count = `SETUP_CYC;
                end
            end
            ST_SETUP:
            begin
                if (tmr_done)
                begin
                    state_d   = ST_STROBE;
                    tmr_load  = 1'b1;
                    tmr_count = `STROBE_CYC;
                    // [R02] only the requested selects go low
                    // [R07] both bits set drives both selects together
                    sel_a_n_d = ~chan_q[`SEL_A_BIT];
                    sel_b_n_d = ~chan_q[`SEL_B_BIT];
                    // [R03] strobe low with select opens the latch
                    // forced low in every mode: a switch into parked mode
                    // leaves the strobe high from the idle cycle
                    wr_n_d = 1'b0;
                end
            end
            ST_STROBE:
            begin
                if (tmr_done)
                begin
                    state_d   = ST_HOLD;
                    tmr_load  = 1'b1;
                    tmr_count = `HOLD_CYC;
                    // [R04] first rising edge captures the code
                    // [R08] tied mode raises strobe and select together
                    sel_a_n_d = 1'b1;
                    sel_b_n_d = 1'b1;
                    if (mode_q != `MODE_WR_LOW)
                        wr_n_d = 1'b1;
                end
            end
            ST_HOLD:
            begin
                // [R10] code held past the closing edge
                if (tmr_done)
                    state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_q    <= ST_IDLE;
            code_q     <= 8'h00;
            chan_q     <= 2'h0;
            mode_q     <= `MODE_SEP;
            wr_n_q     <= 1'b1;
            sel_a_n_q  <= 1'b1;
            sel_b_n_q  <= 1'b1;
            shadow_a_q <= 8'h00;
            shadow_b_q <= 8'h00;
            done_q     <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            wr_n_q    <= wr_n_d;
            sel_a_n_q <= sel_a_n_d;
            sel_b_n_q <= sel_b_n_d;
            done_q    <= (state_q == ST_HOLD) && tmr_done;
            // mode only changes between writes so no edge is glitched
            if (state_q == ST_IDLE)
                mode_q <= strobe_mode;
            if (accept)
            begin
                // [R09] 8-bit code, bit 0 is lsb
                code_q <= req_code;
                chan_q <= req_chan;
            end
            // [R05] device holds once select rises; mirror that here
            if ((state_q == ST_STROBE) && tmr_done)
            begin
                if (chan_q[`SEL_A_BIT])
                    shadow_a_q <= code_q;
                if (chan_q[`SEL_B_BIT])
                    shadow_b_q <= code_q;
            end
        end
    end

endmodule

// ===== design/dual_dac_host_regs.vh
// timing and field constants for the dual converter write controller
`ifndef DUAL_DAC_HOST_REGS_VH
`define DUAL_DAC_HOST_REGS_VH

`define CODE_W          8
`define SETUP_CYC       4'h2
`define STROBE_CYC      4'h3
`define HOLD_CYC        4'h2
`define CNT_W           4
`define SEL_A_BIT       0
`define SEL_B_BIT       1
`define MODE_SEP        2'h0
`define MODE_WR_LOW     2'h1
`define MODE_TIED       2'h2

`endif

// ===== design/phase_timer.v
// phase counter that pulses done after a programmable number of cycles
`include "dual_dac_host_regs.vh"

module phase_timer (
    // clock and reset
    input  wire               clk_sys,
    input  wire               sys_rst,
    // control
    input  wire               load,
    input  wire [`CNT_W-1:0]  count,
    output wire               done
);

    reg  [`CNT_W-1:0] cnt_q;
    reg               run_q;

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cnt_q <= {`CNT_W{1'b0}};
            run_q <= 1'b0;
        end
        else if (load)
        begin
            cnt_q <= count;
            run_q <= 1'b1;
        end
        else if (run_q)
        begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1)
                run_q <= 1'b0;
        end
    end

    assign done = run_q && (cnt_q == 4'h1);

endmodule

// ===== testbench/dac_latch_model.sv
// behavioural model of the two converter input latches
module dac_latch_model (
    // converter pins
    input wire [7:0]   code_bus,
    input wire         write_strobe_n,
    input wire         chan_a_select_n,
    input wire         chan_b_select_n,
    // latch contents
    output logic [7:0] latch_a,
    output logic [7:0] latch_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========
    // latches
    // two write-only bytes
    always_latch
    begin
        if (!write_strobe_n && !chan_a_select_n)
            latch_a <= code_bus;
        if (!write_strobe_n && !chan_b_select_n)
            latch_b <= code_bus;
    end
endmodule

// ===== testbench/dual_dac_host_checker.sv
// pin-timing assertions for the converter write controller
module dual_dac_host_checker (
    // clock and reset
    input wire       clk_sys,
    input wire       sys_rst,
    // user request
    input wire       req_valid,
    input wire       req_ready,
    input wire [1:0] req_chan,
    input wire [1:0] strobe_mode,
    // converter pins
    input wire [7:0] code_bus,
    input wire       write_strobe_n,
    input wire       chan_a_select_n,
    input wire       chan_b_select_n
);
    timeunit 1ns;
    timeprecision 1ns;
    wire acc = req_valid && req_ready && req_chan != 2'h0;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ========
    // pin order
    property p_a_only;
        acc && req_chan == 2'h1 |=> chan_b_select_n [*8];
    endproperty
    a_a_only: assert property (p_a_only) else $error("b select moved");
    property p_b_only;
        acc && req_chan == 2'h2 |=> chan_a_select_n [*8];
    endproperty
    a_b_only: assert property (p_b_only) else $error("a select moved");
    property p_both;
        acc && req_chan == 2'h3 |-> ##[2:8] !chan_a_select_n && !chan_b_select_n;
    endproperty
    a_both: assert property (p_both) else $error("selects not joint");
    property p_hold_bus;
        $rose(chan_a_select_n) || $rose(chan_b_select_n) |-> $stable(code_bus);
    endproperty
    a_hold_bus: assert property (p_hold_bus) else $error("bus moved");
    property p_strobe_sel;
        !chan_a_select_n || !chan_b_select_n |-> !write_strobe_n;
    endproperty
    a_strobe_sel: assert property (p_strobe_sel) else $error("no strobe");
    property p_tied;
        strobe_mode != 2'h1 && $rose(write_strobe_n)
            |-> chan_a_select_n && chan_b_select_n;
    endproperty
    a_tied: assert property (p_tied) else $error("strobe apart");
    property p_parked;
        acc && strobe_mode == 2'h1 |-> ##3 !write_strobe_n [*4];
    endproperty
    a_parked: assert property (p_parked) else $error("strobe high");
    property p_busy;
        acc |=> !req_ready [*7];
    endproperty
    a_busy: assert property (p_busy) else $error("ready early");
endmodule
bind dual_dac_host dual_dac_host_checker dual_dac_host_checker_i (.*);

// ===== testbench/dual_dac_host_tb.sv
// self-checking bench for the converter write controller
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin num_errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module dual_dac_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys = 0, sys_rst = 1, req_valid = 0;
    logic [1:0] req_chan = 0, strobe_mode = 0;
    logic [7:0] req_code = 0, exp_a = 0, exp_b = 0;
    wire        req_ready, write_done, write_strobe_n;
    wire        chan_a_select_n, chan_b_select_n;
    wire [7:0]  shadow_a, shadow_b, code_bus, latch_a, latch_b;
    int         num_errors = 0, checks = 0, n, seen;
    dual_dac_host dual_dac_host_i (.*);
    dac_latch_model dac_latch_model_i (.*);
    always #25 clk_sys = ~clk_sys;
    // ========
    // tasks
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_write(input logic [1:0] ch, input logic [7:0] cd,
                            input logic [1:0] md);
        for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge clk_sys);
        if (n == 20)
        begin
            num_errors++;
            give_verdict();
        end
        {req_valid, req_chan, req_code, strobe_mode} = {1'b1, ch, cd, md};
        @(negedge clk_sys);
        req_valid = 0;
        for (n = 0; n < 20 && write_done !== 1'b1; n++) @(negedge clk_sys);
        if (n == 20)
        begin
            num_errors++;
            give_verdict();
        end
        if (ch[0]) exp_a = cd;
        if (ch[1]) exp_b = cd;
        `CHK("shadow_a", exp_a, shadow_a)
        `CHK("shadow_b", exp_b, shadow_b)
        `CHK("latch_a", exp_a, latch_a)
        `CHK("latch_b", exp_b, latch_b)
        `CHK("code_bus", cd, code_bus)
        // parked mode keeps the strobe low after the write
        if (md == 2'h1)
            `CHK("strobe_park", 1'b0, write_strobe_n)
    endtask
    initial
    begin
        void'($urandom(38));
        repeat (8) @(negedge clk_sys);
        sys_rst = 0;
        `CHK("sel_idle", 2'h3, {chan_a_select_n, chan_b_select_n})
        do_write(2'h3, 8'h00, 2'h0);
        do_write(2'h3, 8'hff, 2'h2);
        {req_valid, req_chan, seen} = 0;
        req_valid = 1;
        repeat (15) @(negedge clk_sys) if (write_done !== 1'b0) seen++;
        `CHK("ready_refused", 1'b1, req_ready)
        req_valid = 0;
        `CHK("refused", 0, seen)
        for (int i = 0; i < 30; i++)
            do_write(2'(1 + $urandom % 3), 8'($urandom), 2'(i % 3));
        give_verdict();
    end
endmodule
